// ### bench/aog_ext_dev.sv
`timescale 1ns/100ps
// ==================================================================
// External device that drives the digital input pins.
// ==================================================================
module aog_ext_dev (
    input wire logic clk_in,
    input wire logic fire_in,
    input wire logic [3:0] idx_in,
    output logic [15:0] pin_out = 16'h0
);
    int cnt = 0; // Cycles left in the current pulse.
    // Pins rest low; a request sends one 10-cycle (100 ns) high pulse.
    always @(posedge clk_in) begin
        if (fire_in && cnt == 0) cnt = 10;
        pin_out <= (cnt > 0) ? (16'h1 << idx_in) : 16'h0;
        if (cnt > 0) cnt = cnt - 1;
    end
endmodule : aog_ext_dev

// ### bench/tb_top.sv
`timescale 1ns/100ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin fail_count++; \
    $display("[ERR] %0t got %0h exp %0h", $time, a, b); end end
// ==================================================================
// Bench top: drives the block at the falling edge and checks pins.
// ==================================================================
module tb_top;
    logic clk = 0, rst_n = 0, fire = 0; // Clock, reset, device request.
    logic [7:0] on = 0, fe = 0, le = 0, af = 0, st = 0, fc = 0, um = 0, ud = 0;
    logic [7:0] ce = 0, co = 0, cl = 0, cg = 0, cv = 0, cp;
    logic [3:0] rt = 0, cen = 0, dd, ae, fh, cap, idx = 4'h4;
    logic [15:0] gpi, gl = 0, gv = 0, gll = 0, ga, gp;
    logic [1:0] gs = 0; // Compare routing onto outputs 1 and 9.
    int fail_count = 0, tests_run = 0, n;
    // The clock toggles every 5 ns.
    initial forever #5 clk = ~clk;
    aog_axis_io #(.CMP_PULSE_CYC(20), .SERVO_GAP_CYC(25), .STEP_GAP_CYC(30),
        .CAP_GAP_CYC(10)) aog_axis_io_i (.CLK_IN(clk), .RESETN_IN(rst_n),
        .AXIS_ON_IN(on), .FOLLOW_ERR_IN(fe), .LIMIT_ERR_IN(le), .AMP_FAULT_IN(af),
        .STEPPER_AXIS_IN(st), .ROUTE_PULSE_AXIS_IN(rt), .FULL_CURRENT_SELECT_IN(fc),
        .UNIPOLAR_MODE_IN(um), .UNIPOLAR_DIR_NEG_IN(ud), .CMP_EVENT_IN(ce),
        .CMP_ONESHOT_IN(co), .CMP_LOW_ACT_IN(cl), .CMP_AS_GPO_IN(cg),
        .CMP_GPO_VAL_IN(cv), .GPI_PIN_IN(gpi), .GPI_LOW_ACT_IN(gl),
        .CAP_ENABLE_IN(cen), .GPO_VAL_IN(gv), .GPO_LOW_ACT_IN(gll),
        .GPO_CMP_SEL_IN(gs), .DRV_DISABLE_N_OUT(dd), .AMP_ENABLE_N_OUT(ae),
        .FULL_HALF_N_OUT(fh), .CMP_PIN_OUT(cp), .GPI_ACTIVE_OUT(ga),
        .CAPTURE_OUT(cap), .GPO_PIN_OUT(gp));
    aog_ext_dev aog_ext_dev_i (.clk_in(clk), .fire_in(fire), .idx_in(idx), .pin_out(gpi));
    // Waits a number of falling edges.
    task step(input int k);
        repeat (k) @(negedge clk);
    endtask : step
    // Sends a one-cycle compare event on one axis.
    task ev(input int a);
        ce[a] = 1;
        step(1);
        ce[a] = 0;
    endtask : ev
    // Prints the verdict and stops.
    task test_done;
        if (fail_count == 0 && tests_run > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : test_done
    // Main sequence of scenarios.
    initial begin
        step(10);
        `CHK(dd, 4'h0) `CHK(ae, 4'hF) `CHK(fh, 4'hF) `CHK(gp, 16'h0)
        rst_n = 1;
        on = 8'h11;
        step(3);
        `CHK(dd[0], 1'b1) `CHK(ae[0], 1'b0)
        rt[0] = 1;
        on[4] = 0;
        step(2);
        `CHK(dd[0], 1'b0) `CHK(ae[0], 1'b1)
        rt[0] = 0;
        // Each error kind in turn must stop the driver.
        for (int i = 0; i < 3; i++) begin
            fe[0] = (i == 0);
            le[0] = (i == 1);
            af[0] = (i == 2);
            step(2);
            `CHK({dd[0], ae[0]}, 2'b01)
            {fe, le, af} = 0;
            step(2);
            `CHK({dd[0], ae[0]}, 2'b10)
        end
        fc[0] = 1;
        step(2);
        `CHK(fh[0], 1'b0)
        fc[0] = 0;
        {um[0], ud[0]} = 2'b11;
        step(2);
        `CHK(fh[0], 1'b0)
        ud[0] = 0;
        step(2);
        `CHK(fh[0], 1'b1)
        // One-shot width, with a second event landing inside the pulse.
        co[1] = 1;
        ev(1);
        n = 0;
        for (int k = 0; k < 40; k++) begin
            ce[1] = (k == 5);
            step(1);
            if (cp[1] === 1'b1) n++;
        end
        `CHK(n, 20)
        cl[1] = 1;
        step(2);
        `CHK(cp[1], 1'b1)
        cl[1] = 0;
        co[1] = 0;
        ev(1);
        step(4);
        ev(1);
        step(4);
        `CHK(cp[1], 1'b1)
        step(30);
        ev(1);
        step(4);
        `CHK(cp[1], 1'b0)
        {cg[1], cv[1]} = 2'b11;
        step(2);
        `CHK(cp[1], 1'b1)
        {cg[1], cv[1]} = 0;
        gv = 16'h00A5;
        step(2);
        `CHK(gp, 16'h00A5)
        gll = 16'hFFFF;
        step(2);
        `CHK(gp, 16'hFF5A)
        {gll, gv} = 0;
        gs = 2'h1;
        co[2] = 1;
        ev(2);
        step(4);
        `CHK(gp[0], 1'b1)
        // Stepper holdoff on an upper axis, shown on output 9 as well.
        {gs, st[7]} = 3'h5;
        ev(7);
        step(4);
        `CHK(gp[8], 1'b1)
        step(23);
        ev(7);
        step(4);
        `CHK(cp[7], 1'b1)
        step(5);
        ev(7);
        step(4);
        `CHK(cp[7], 1'b0)
        // Capture from input 5 for axis pair 3/4.
        cen = 4'h2;
        fire = 1;
        step(1);
        fire = 0;
        n = 0;
        for (int k = 0; k < 20; k++) begin
            step(1);
            if (cap[1] === 1'b1) n++;
        end
        `CHK(n, 1)
        gl[4] = 1;
        step(4);
        `CHK(ga[4], 1'b1)
        rst_n = 0;
        step(2);
        `CHK({dd[0], ae[0]}, 2'b01)
        test_done();
    end
endmodule : tb_top

// ### logic/aog_axis_io.sv
`timescale 1ns/100ps
// What this block does
// R1: Disable output sinks when axis off or reset.
// R2: Disable output releases high at once when on.
// R3: Any axis error asserts the disable output.
// R4: Enabled axis drives enable output low.
// R5: Axis off or reset releases enable high.
// R6: Any axis error releases the enable output.
// R7: Compare event drives compare pin, programmable polarity.
// R8: One-shot compare pulse lasts one millisecond.
// R9: Compare retriggers at 4 kHz servo, 1 kHz stepper.
// R10: Compare pin usable as plain digital output.
// R11: Current select idles high, full current low.
// R12: Unipolar mode puts direction on that output.
// R13: Sixteen digital inputs with programmable active level.
// R14: Inputs 1,5,9,13 trigger capture per axis pair.
// R15: Sixteen digital outputs, programmable level, default high.
// R16: Outputs 1 and 9 can show compares.
// R17: Axis pairs share drivers; assignment is selectable.
// R18: Capture fires on rising edge, 100 ns, 1 kHz.
// R19: Counter times pulse; events during it dropped.
module aog_axis_io #(
    parameter int NUM_AXES = 8,
    parameter int CMP_PULSE_CYC = aog_pkg::CMP_PULSE_CYC,
    parameter int SERVO_GAP_CYC = aog_pkg::SERVO_GAP_CYC,
    parameter int STEP_GAP_CYC = aog_pkg::STEP_GAP_CYC,
    parameter int CAP_GAP_CYC = aog_pkg::CAP_GAP_CYC
) (
    input wire logic CLK_IN,
    input wire logic RESETN_IN,
    // Axis state and errors from the motion logic.
    input wire logic [NUM_AXES-1:0] AXIS_ON_IN,
    input wire logic [NUM_AXES-1:0] FOLLOW_ERR_IN,
    input wire logic [NUM_AXES-1:0] LIMIT_ERR_IN,
    input wire logic [NUM_AXES-1:0] AMP_FAULT_IN,
    input wire logic [NUM_AXES-1:0] STEPPER_AXIS_IN,
    // Driver ownership, current select and unipolar direction.
    input wire logic [NUM_AXES/2-1:0] ROUTE_PULSE_AXIS_IN,
    input wire logic [NUM_AXES-1:0] FULL_CURRENT_SELECT_IN,
    input wire logic [NUM_AXES-1:0] UNIPOLAR_MODE_IN,
    input wire logic [NUM_AXES-1:0] UNIPOLAR_DIR_NEG_IN,
    // Position compare.
    input wire logic [NUM_AXES-1:0] CMP_EVENT_IN,
    input wire logic [NUM_AXES-1:0] CMP_ONESHOT_IN,
    input wire logic [NUM_AXES-1:0] CMP_LOW_ACT_IN,
    input wire logic [NUM_AXES-1:0] CMP_AS_GPO_IN,
    input wire logic [NUM_AXES-1:0] CMP_GPO_VAL_IN,
    // General-purpose inputs and capture.
    input wire logic [aog_pkg::NUM_GPIO-1:0] GPI_PIN_IN,
    input wire logic [aog_pkg::NUM_GPIO-1:0] GPI_LOW_ACT_IN,
    input wire logic [aog_pkg::NUM_CAP-1:0] CAP_ENABLE_IN,
    // General-purpose outputs.
    input wire logic [aog_pkg::NUM_GPIO-1:0] GPO_VAL_IN,
    input wire logic [aog_pkg::NUM_GPIO-1:0] GPO_LOW_ACT_IN,
    input wire logic [1:0] GPO_CMP_SEL_IN,
    // Pins and status.
    output logic [NUM_AXES/2-1:0] DRV_DISABLE_N_OUT,
    output logic [NUM_AXES/2-1:0] AMP_ENABLE_N_OUT,
    output logic [NUM_AXES/2-1:0] FULL_HALF_N_OUT,
    output logic [NUM_AXES-1:0] CMP_PIN_OUT,
    output logic [aog_pkg::NUM_GPIO-1:0] GPI_ACTIVE_OUT,
    output logic [aog_pkg::NUM_CAP-1:0] CAPTURE_OUT,
    output logic [aog_pkg::NUM_GPIO-1:0] GPO_PIN_OUT
);

    // Drivers are shared by an analog axis and its pulse partner.
    localparam int NUM_CH = NUM_AXES / 2;
    localparam int CAP_W = $clog2(CAP_GAP_CYC + 1);
    typedef logic [CAP_W-1:0] aog_cap_cnt_t;
    localparam aog_cap_cnt_t CAP_LD = aog_cap_cnt_t'(CAP_GAP_CYC - 1);
    localparam aog_cap_cnt_t CAP_ONE = aog_cap_cnt_t'(1);

    // ==================================================================
    // Elaboration checks.
    // ==================================================================
    // The axis count must pair up and fit the two compare outputs.
    if (NUM_AXES < 2 || NUM_AXES > 8 || (NUM_AXES % 2) != 0) begin : g_bad_axes
        $error("aog_axis_io: NUM_AXES must be 2, 4, 6 or 8.");
    end
    // A capture pulse must survive the two-stage input synchroniser.
    if (aog_pkg::CAP_MIN_PULSE_CYC < 2 || CAP_GAP_CYC < 1) begin : g_bad_cap
        $error("aog_axis_io: capture timing cannot be served at this clock.");
    end

    // ==================================================================
    // Axis enable and disable outputs.
    // ==================================================================
    wire [NUM_AXES-1:0] axis_err;   // Any error on the axis.
    wire [NUM_AXES-1:0] axis_run;   // Axis on and free of errors.
    wire [NUM_CH-1:0] ch_run;       // Run state of the axis that owns the driver.
    wire [NUM_CH-1:0] ch_curr_n;    // Next level of the current or direction pin.
    logic [NUM_CH-1:0] drv_dis_n_q; // Disable pin level, low sinks.
    logic [NUM_CH-1:0] amp_en_n_q;  // Enable pin level, low sinks.
    logic [NUM_CH-1:0] curr_n_q;    // Current or direction pin level.

    // Following error, limit and amplifier fault all count as errors.
    assign axis_err = FOLLOW_ERR_IN | LIMIT_ERR_IN | AMP_FAULT_IN; // R3
    assign axis_run = AXIS_ON_IN & ~axis_err; // R6

    // Each driver follows the analog axis or its pulse partner.
    for (genvar k = 0; k < NUM_CH; k++) begin : g_chan
        wire own_pulse;     // Driver owned by the pulse axis.
        wire own_uni;       // Owner axis is in unipolar mode.
        wire own_dir;       // Owner axis commands the negative direction.
        wire own_full;      // Owner axis selects full current.
        assign own_pulse = ROUTE_PULSE_AXIS_IN[k]; // R17
        assign ch_run[k] = own_pulse ? axis_run[k+NUM_CH] : axis_run[k]; // R17
        assign own_uni = own_pulse ? UNIPOLAR_MODE_IN[k+NUM_CH] : UNIPOLAR_MODE_IN[k];
        assign own_dir = own_pulse ? UNIPOLAR_DIR_NEG_IN[k+NUM_CH] : UNIPOLAR_DIR_NEG_IN[k];
        assign own_full = own_pulse ? FULL_CURRENT_SELECT_IN[k+NUM_CH] :
                          FULL_CURRENT_SELECT_IN[k];
        // Unipolar mode carries direction; otherwise full current pulls low.
        assign ch_curr_n[k] = own_uni ? !own_dir : !own_full; // R11 R12
    end

    // Driver pin registers; reset holds disable active and enable released.
    always_ff @(posedge CLK_IN) begin
        if (!RESETN_IN) begin
            drv_dis_n_q <= {NUM_CH{aog_pkg::RST_DRV_DISABLE_N}}; // R1
            amp_en_n_q <= {NUM_CH{aog_pkg::RST_AMP_ENABLE_N}}; // R5
            curr_n_q <= {NUM_CH{aog_pkg::RST_FULL_HALF_N}}; // R11
        end else begin
            drv_dis_n_q <= ch_run; // R1 R2 R3
            amp_en_n_q <= ~ch_run; // R4 R5 R6
            curr_n_q <= ch_curr_n; // R11 R12
        end
    end

    assign DRV_DISABLE_N_OUT = drv_dis_n_q;
    assign AMP_ENABLE_N_OUT = amp_en_n_q;
    assign FULL_HALF_N_OUT = curr_n_q;

    // ==================================================================
    // Position compare outputs.
    // ==================================================================
    wire [NUM_AXES-1:0] cmp_act;    // Compare state of each axis.
    wire [NUM_AXES-1:0] cmp_level;  // Active state shown on the pin.
    logic [NUM_AXES-1:0] cmp_pin_q; // Compare pin register.

    // One compare channel per axis.
    for (genvar a = 0; a < NUM_AXES; a++) begin : g_cmp
        aog_cmp_chan #(
            .PULSE_CYC(CMP_PULSE_CYC),
            .SERVO_GAP(SERVO_GAP_CYC),
            .STEP_GAP(STEP_GAP_CYC)
        ) u_cmp (
            .clk_in(CLK_IN),
            .rst_n_in(RESETN_IN),
            .event_in(CMP_EVENT_IN[a]),
            .oneshot_in(CMP_ONESHOT_IN[a]),
            .stepper_in(STEPPER_AXIS_IN[a]),
            .active_out(cmp_act[a]),
            .busy_out()
        );
    end

    // The pin shows either the compare state or a plain output value.
    assign cmp_level = (CMP_AS_GPO_IN & CMP_GPO_VAL_IN) | (~CMP_AS_GPO_IN & cmp_act); // R10

    // Compare pin register with programmable polarity, active high by default.
    always_ff @(posedge CLK_IN) begin
        if (!RESETN_IN) begin
            cmp_pin_q <= {NUM_AXES{aog_pkg::RST_CMP_PIN}};
        end else begin
            cmp_pin_q <= cmp_level ^ CMP_LOW_ACT_IN; // R7
        end
    end

    assign CMP_PIN_OUT = cmp_pin_q;

    // ==================================================================
    // General-purpose inputs and position capture.
    // ==================================================================
    logic [aog_pkg::NUM_GPIO-1:0] gpi_meta_q;   // First synchroniser stage.
    logic [aog_pkg::NUM_GPIO-1:0] gpi_sync_q;   // Second synchroniser stage.
    logic [aog_pkg::NUM_GPIO-1:0] gpi_act_q;    // Input in its active sense.
    logic [aog_pkg::NUM_GPIO-1:0] gpi_prev_q;   // Active sense one cycle earlier.
    logic [aog_pkg::NUM_CAP-1:0] cap_q;         // Capture trigger pulses.
    logic [3:0] gpi_arm_q;                      // Fills with ones as the input chain settles.
    wire [aog_pkg::NUM_CAP-1:0] cap_take;       // Capture accepted this cycle.

    // Pins cross into the clock domain, then take their programmed sense.
    always_ff @(posedge CLK_IN) begin
        if (!RESETN_IN) begin
            gpi_meta_q <= '0;
            gpi_sync_q <= '0;
            gpi_act_q <= '0;
            gpi_prev_q <= '0;
        end else begin
            gpi_meta_q <= GPI_PIN_IN;
            gpi_sync_q <= gpi_meta_q;
            gpi_act_q <= gpi_sync_q ^ GPI_LOW_ACT_IN; // R13
            gpi_prev_q <= gpi_act_q;
        end
    end

    assign GPI_ACTIVE_OUT = gpi_act_q;

    // Edge detection waits until every stage holds a real pin sample.
    // Without it, a pin that idles in its active sense would look like a
    // fresh rising edge straight after reset and fire a false capture.
    always_ff @(posedge CLK_IN) begin
        if (!RESETN_IN) begin
            gpi_arm_q <= 4'h0;
        end else begin
            gpi_arm_q <= {gpi_arm_q[2:0], 1'h1};
        end
    end

    // Inputs 1, 5, 9 and 13 each trigger capture for one axis pair.
    for (genvar p = 0; p < aog_pkg::NUM_CAP; p++) begin : g_cap
        localparam int IDX = p * aog_pkg::CAP_STRIDE;
        aog_cap_cnt_t hold_q;   // Retrigger holdoff count.
        wire rise;              // Rising edge of the active sense.
        assign rise = gpi_arm_q[3] && gpi_act_q[IDX] && !gpi_prev_q[IDX]; // R18
        assign cap_take[p] = CAP_ENABLE_IN[p] && rise && (hold_q == '0); // R14 R18

        // Holdoff keeps the retrigger rate at or below its limit.
        always_ff @(posedge CLK_IN) begin
            if (!RESETN_IN) begin
                hold_q <= '0;
            end else if (cap_take[p]) begin
                hold_q <= CAP_LD; // R18
            end else if (hold_q != '0) begin
                hold_q <= hold_q - CAP_ONE;
            end
        end
    end

    // Capture pulses are registered for one cycle.
    always_ff @(posedge CLK_IN) begin
        if (!RESETN_IN) begin
            cap_q <= '0;
        end else begin
            cap_q <= cap_take; // R14
        end
    end

    assign CAPTURE_OUT = cap_q;

    // ==================================================================
    // General-purpose outputs.
    // ==================================================================
    wire cmp_any_lo;                        // Compare on the lower axes.
    wire cmp_any_hi;                        // Compare on the upper axes.
    logic [aog_pkg::NUM_GPIO-1:0] gpo_val;  // Output values before polarity.
    logic [aog_pkg::NUM_GPIO-1:0] gpo_pin_q;// Output pin register.

    assign cmp_any_lo = |cmp_act[NUM_CH-1:0];
    assign cmp_any_hi = |cmp_act[NUM_AXES-1:NUM_CH];

    // Outputs 1 and 9 may carry compare events instead of their value.
    always_comb begin
        gpo_val = GPO_VAL_IN;
        if (GPO_CMP_SEL_IN[0]) begin
            gpo_val[aog_pkg::GPO_CMP_LO] = cmp_any_lo; // R16
        end
        if (GPO_CMP_SEL_IN[1]) begin
            gpo_val[aog_pkg::GPO_CMP_HI] = cmp_any_hi; // R16
        end
    end

    // Output pins, active high unless a bit asks for active low.
    always_ff @(posedge CLK_IN) begin
        if (!RESETN_IN) begin
            gpo_pin_q <= {aog_pkg::NUM_GPIO{aog_pkg::RST_GPO_PIN}};
        end else begin
            gpo_pin_q <= gpo_val ^ GPO_LOW_ACT_IN; // R15
        end
    end

    assign GPO_PIN_OUT = gpo_pin_q;

    // ==================================================================
    // Checks.
    // ==================================================================
    sequence s_rise(int i);
        $past(gpi_act_q[i]) && !$past(gpi_prev_q[i]);
    endsequence

    chk_reset_pins: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN) // R1
        $rose(RESETN_IN) |-> DRV_DISABLE_N_OUT == '0 && AMP_ENABLE_N_OUT == '1)
        else $error("Driver pins not in their reset state after reset.");

    chk_pins_opposite: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN) // R4
        DRV_DISABLE_N_OUT == ~AMP_ENABLE_N_OUT)
        else $error("Disable and enable pins disagree.");

    for (genvar c = 0; c < NUM_CH; c++) begin : g_chk_ch
        chk_err_disable: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN) // R3
            (ROUTE_PULSE_AXIS_IN[c] ? axis_err[c+NUM_CH] : axis_err[c])
            |=> !DRV_DISABLE_N_OUT[c] && AMP_ENABLE_N_OUT[c])
            else $error("Axis error did not disable the driver.");

        chk_on_release: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN) // R2
            (ROUTE_PULSE_AXIS_IN[c] ? axis_run[c+NUM_CH] : axis_run[c])
            |=> DRV_DISABLE_N_OUT[c] && !AMP_ENABLE_N_OUT[c])
            else $error("Running axis did not release disable at once.");
    end

    chk_cmp_level: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN) // R7
        ##1 CMP_PIN_OUT == ($past(cmp_level) ^ $past(CMP_LOW_ACT_IN)))
        else $error("Compare pin does not follow state and polarity.");

    for (genvar q = 0; q < aog_pkg::NUM_CAP; q++) begin : g_chk_cap
        chk_cap_edge: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN) // R18
            CAPTURE_OUT[q] |-> s_rise(q * aog_pkg::CAP_STRIDE))
            else $error("Capture fired without a rising edge.");

        chk_cap_single: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN) // R14
            CAPTURE_OUT[q] |=> !CAPTURE_OUT[q] [*2])
            else $error("Capture retriggered inside its holdoff.");
    end

endmodule : aog_axis_io

// ### logic/aog_cmp_chan.sv
`timescale 1ns/100ps
// ==================================================================
// One position-compare channel: one-shot timer, toggle mode, holdoff.
// ==================================================================
module aog_cmp_chan #(
    parameter int PULSE_CYC = aog_pkg::CMP_PULSE_CYC,
    parameter int SERVO_GAP = aog_pkg::SERVO_GAP_CYC,
    parameter int STEP_GAP = aog_pkg::STEP_GAP_CYC
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic event_in,
    input wire logic oneshot_in,
    input wire logic stepper_in,
    output logic active_out,
    output logic busy_out
);

    // Counter width that holds the longest of the three counts.
    localparam int MAX_CYC = (PULSE_CYC > SERVO_GAP) ?
        ((PULSE_CYC > STEP_GAP) ? PULSE_CYC : STEP_GAP) :
        ((SERVO_GAP > STEP_GAP) ? SERVO_GAP : STEP_GAP);
    localparam int CNT_W = $clog2(MAX_CYC + 1);
    typedef logic [CNT_W-1:0] aog_cnt_t;
    localparam aog_cnt_t PULSE_LD = aog_cnt_t'(PULSE_CYC);
    localparam aog_cnt_t SERVO_LD = aog_cnt_t'(SERVO_GAP - 1);
    localparam aog_cnt_t STEP_LD = aog_cnt_t'(STEP_GAP - 1);
    localparam aog_cnt_t CNT_ONE = aog_cnt_t'(1);

    // Refuse counts that the counters cannot serve.
    if (PULSE_CYC < 1 || SERVO_GAP < 1 || STEP_GAP < 1) begin : g_bad_cnt
        $error("aog_cmp_chan: every count must be at least one cycle.");
    end

    aog_cnt_t pulse_q;  // Remaining cycles of the one-shot pulse.
    aog_cnt_t pulse_d;  // Next pulse count.
    aog_cnt_t gap_q;    // Remaining cycles before a retrigger is allowed.
    aog_cnt_t gap_d;    // Next holdoff count.
    logic active_q;     // Compare state before polarity.
    logic active_d;     // Next compare state.
    wire busy;          // A pulse or holdoff is still running.
    wire accept;        // Event taken this cycle.

    // An event in the middle of a pulse or holdoff is dropped.
    assign busy = (pulse_q != '0) || (gap_q != '0); // R19
    assign accept = event_in && !busy; // R19
    // The one-shot pulse is loaded on an accepted event and counts down.
    assign pulse_d = (accept && oneshot_in) ? PULSE_LD :
                     ((pulse_q != '0) ? pulse_q - CNT_ONE : '0); // R8
    // The holdoff sets the retrigger rate by axis type.
    assign gap_d = accept ? (stepper_in ? STEP_LD : SERVO_LD) :
                   ((gap_q != '0) ? gap_q - CNT_ONE : '0); // R9
    // One-shot mode shows the running pulse; otherwise each accepted event toggles.
    assign active_d = oneshot_in ? (pulse_d != '0) : (active_q ^ accept); // R8

    // Counters and compare state.
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            pulse_q <= '0;
            gap_q <= '0;
            active_q <= 1'h0;
        end else begin
            pulse_q <= pulse_d;
            gap_q <= gap_d;
            active_q <= active_d;
        end
    end

    assign active_out = active_q;
    assign busy_out = busy;

    // ==================================================================
    // Checks.
    // ==================================================================
    logic [CNT_W:0] hi_cnt_q;   // Length of the present high phase.
    logic [CNT_W:0] since_q;    // Cycles since the last accepted event.

    // Helper counters that only the checks read.
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            hi_cnt_q <= '0;
            since_q <= '1;
        end else begin
            hi_cnt_q <= active_q ? hi_cnt_q + 1'h1 : '0;
            since_q <= accept ? '0 : ((&since_q) ? since_q : since_q + 1'h1);
        end
    end

    chk_pulse_width: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R8
        $fell(active_q) && oneshot_in && $past(oneshot_in) && $past(hi_cnt_q) != '0
        |-> $past(hi_cnt_q) + 1'h1 == (CNT_W + 1)'(PULSE_CYC))
        else $error("One-shot compare pulse has the wrong length.");

    chk_busy_ignore: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R19
        event_in && busy && !oneshot_in |=> $stable(active_q))
        else $error("Compare event taken while a pulse or holdoff ran.");

    chk_retrig_gap: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R9
        accept && !(&since_q) |-> since_q + 1'h1 >= (CNT_W + 1)'(SERVO_GAP < STEP_GAP ?
                                                                   SERVO_GAP : STEP_GAP))
        else $error("Compare retriggered faster than the holdoff allows.");

endmodule : aog_cmp_chan

// ### logic/aog_pkg.sv
// ==================================================================
// Shared constants for the axis output and general-purpose I/O block.
// ==================================================================
package aog_pkg;

    // ==================================================================
    // Clock and timing figures in their own units.
    // ==================================================================
    localparam int CLK_FREQ_MHZ = 100;      // System clock rate in MHz.
    localparam int CMP_PULSE_US = 1000;     // One-shot compare pulse, 1 ms nominal.
    localparam int CMP_TOL_US = 500;        // Allowed deviation of that pulse, 0.5 ms.
    localparam int SERVO_RETRIG_HZ = 4000;  // Compare retrigger rate on a servo axis.
    localparam int STEP_RETRIG_HZ = 1000;   // Compare retrigger rate on a stepper axis.
    localparam int CAP_RETRIG_HZ = 1000;    // Capture input retrigger rate.
    localparam int CAP_MIN_PULSE_NS = 100;  // Shortest capture pulse that must be seen.

    // ==================================================================
    // Timing counts in clock cycles, derived from the figures above.
    // ==================================================================
    localparam int CMP_PULSE_CYC = CMP_PULSE_US * CLK_FREQ_MHZ;
    localparam int CMP_TOL_CYC = CMP_TOL_US * CLK_FREQ_MHZ;
    localparam int SERVO_GAP_CYC = (CLK_FREQ_MHZ * 1000000 + SERVO_RETRIG_HZ - 1) / SERVO_RETRIG_HZ;
    localparam int STEP_GAP_CYC = (CLK_FREQ_MHZ * 1000000 + STEP_RETRIG_HZ - 1) / STEP_RETRIG_HZ;
    localparam int CAP_GAP_CYC = (CLK_FREQ_MHZ * 1000000 + CAP_RETRIG_HZ - 1) / CAP_RETRIG_HZ;
    localparam int CAP_MIN_PULSE_CYC = (CAP_MIN_PULSE_NS * CLK_FREQ_MHZ + 999) / 1000;

    // ==================================================================
    // Channel layout of the general-purpose I/O banks.
    // ==================================================================
    localparam int NUM_GPIO = 16;       // Inputs and outputs per bank.
    localparam int NUM_CAP = 4;         // Capture-capable inputs, one per axis pair.
    localparam int CAP_STRIDE = 4;      // Inputs 1, 5, 9, 13 sit at indices 0, 4, 8, 12.
    localparam int GPO_CMP_LO = 0;      // Output 1 can show compares of the lower axes.
    localparam int GPO_CMP_HI = 8;      // Output 9 can show compares of the upper axes.

    // ==================================================================
    // Reset values of the output pins.
    // ==================================================================
    localparam logic RST_DRV_DISABLE_N = 1'h0;  // Disable driver sinks during reset.
    localparam logic RST_AMP_ENABLE_N = 1'h1;   // Enable driver released during reset.
    localparam logic RST_FULL_HALF_N = 1'h1;    // Current select inactive high.
    localparam logic RST_CMP_PIN = 1'h0;        // Compare pin at its inactive level.
    localparam logic RST_GPO_PIN = 1'h0;        // Digital outputs at inactive level.

endpackage : aog_pkg
